// *** dv/mht_line_model.sv ***
`timescale 1ns/1ps
// Far-side line: ring pulse trains on request, idle line stays low
module mht_line_model
(
   input wire logic clk,
   output logic pin_ring_pulse
);
   initial pin_ring_pulse = 1'b0;
   // Equal high and low halves; the burst on-time runs from the first to the last rising edge
   task automatic ring(input int n, input int half);
      repeat (n)
      begin
         repeat (half) @(posedge clk);
         pin_ring_pulse <= 1'b1;
         repeat (half) @(posedge clk);
         pin_ring_pulse <= 1'b0;
      end
   endtask
endmodule

// *** dv/mht_top_tb.sv ***
`timescale 1ns/1ps
module mht_top_tb;
   import mht_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq, tone, ring;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic off_hook = 1'b0, ans_mode = 1'b0, loop_over = 1'b0, det = 1'b0, hs = 1'b0;
   logic fsk, res_n;
   logic [7:0] evt, kbits;
   int n_errors = 0, compares = 0, cyc = 0, n;
   always #10 clk = ~clk;
   mht_line_model line (.clk(clk), .pin_ring_pulse(ring));
   mht_top #(.BASE_CYCLES(10)) DUT (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pin_off_hook(off_hook), .pin_answer_mode(ans_mode), .pin_v22_orig(det),
      .pin_answer_tone_det(det), .pin_scr_ones_det(det), .pin_kissoff_det(det),
      .pin_carrier_det(det), .pin_ring_pulse(ring), .pin_handshake_end(hs),
      .pin_loop_over(loop_over), .pin_loop_volt(8'h5c), .pin_loop_curr(8'ha3),
      .pin_intrusion_state(8'h6b), .irq(irq), .answer_tone_tx(tone), .fsk_link_up(fsk),
      .event_pulse(evt), .result_n(res_n), .kissoff_ctrl_bits(kbits));
   task automatic stop_test;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e)
      begin
         n_errors++;
         $display("ERROR t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Each strobe gets its own cycle plus a gap, so no signal is set twice per step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
      @(posedge clk);
   endtask
   task automatic t_regs;
      for (int i = 0; i < MHT_NRW; i++) rdchk(MHT_RW_ADDR[i], MHT_RW_RST[i]);
      wr(8'h32, 8'h55);
      rdchk(8'h32, 8'h55);
      rdchk(8'h31, 8'h3c);
      wr(8'hdb, 8'h11);
      rdchk(8'hdb, 8'h5c);
      rdchk(8'hd1, 8'h6b);
      wr(8'h40, 8'h77);
      rdchk(8'h40, 8'h00);
   endtask
   // Fine length applies only with the seconds length at zero; tick phase gives slack
   task automatic t_answer;
      wr(8'h32, 8'h02);
      wr(8'h1e, 8'h00);
      wr(8'h3a, 8'h01);
      wr(8'h34, 8'h05);
      off_hook <= 1'b1;
      ans_mode <= 1'b1;
      loop_over <= 1'b1;
      n = 0;
      while (tone !== 1'b1 && n < 800)
      begin
         @(posedge clk);
         n++;
      end
      chk({7'h0, n < 400}, 8'h01);
      n = 0;
      while (tone === 1'b1 && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      chk({7'h0, n >= 40 && n <= 60}, 8'h01);
      rdchk(8'hdb, 8'ha3);
      rdchk(8'hc0, 8'h20);
      chk({7'h0, irq}, 8'h00);
      wr(8'hc1, 8'h20);
      @(posedge clk);
      chk({7'h0, irq}, 8'h01);
      wr(8'hc0, 8'h20);
      @(posedge clk);
      chk({7'h0, irq}, 8'h00);
      off_hook <= 1'b0;
      loop_over <= 1'b0;
   endtask
   // Four pulses pass the minimum of three, two fall short
   task automatic t_ring;
      line.ring(4, 200);
      repeat (5600) @(posedge clk);
      rdchk(8'hc0, 8'h80);
      wr(8'hc0, 8'hff);
      line.ring(2, 400);
      repeat (5600) @(posedge clk);
      rdchk(8'hc0, 8'h00);
   endtask
   // One detector line in alpha then bang-seven; carrier counts back only after a loss
   task automatic t_links;
      wr(8'h31, 8'h02);
      wr(8'h35, 8'h02);
      wr(8'h36, 8'h01);
      wr(8'h37, 8'h02);
      for (int k = 0; k < 3; k++)
      begin
         wr(8'hc2, k < 2 ? 8'h01 : 8'h03);
         det <= 1'b1;
         repeat (400) @(posedge clk);
         det <= 1'b0;
         repeat (8) @(posedge clk);
         rdchk(8'hc0, k[1] ? 8'h0b : (k[0] ? 8'h0f : 8'h07));
         wr(8'hc0, 8'hff);
      end
      chk(kbits, 8'h01);
      wr(8'h39, 8'h01);
      off_hook <= 1'b1;
      n = 0;
      while (res_n !== 1'b1 && n < 7000)
      begin
         @(posedge clk);
         n++;
      end
      chk(evt, 8'h40);
      rdchk(8'hc0, 8'h40);
      wr(8'hc2, 8'h00);
      wr(8'h30, 8'h01);
      wr(8'h2f, 8'h04);
      hs <= 1'b1;
      n = 0;
      while (fsk !== 1'b1 && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      chk({7'h0, n >= 2590 && n <= 2615}, 8'h01);
      chk(evt, 8'h10);
      hs <= 1'b0;
      off_hook <= 1'b0;
   endtask
   // Hang guard sized well past the roughly 21k cycles of traffic
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 50000)
      begin
         n_errors++;
         stop_test();
      end
   end
   initial
   begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_answer();
      t_ring();
      t_links();
      stop_test();
   end
endmodule

// *** inc/mht_pkg.sv ***
`include "mht_regs.svh"
package mht_pkg;
   typedef enum logic [1:0] {MODE_NONE, MODE_ALPHA, MODE_BANG1, MODE_BANG7} mht_mode_t;
   typedef enum {ANS_IDLE, ANS_DELAY, ANS_TONE, ANS_DONE} mht_ans_t;
   localparam int MHT_NRW = 24;
   localparam int IX_FSKL = 0, IX_TSEC = 1, IX_FSKH = 2, IX_ADET = 3, IX_OCD = 4;
   localparam int IX_TFINE = 6, IX_SCR = 7, IX_KISS = 8, IX_CRET = 9, IX_CWAIT = 11;
   localparam int IX_ADLY = 12, IX_RPMIN = 13, IX_CTRL = 19, IX_RONMIN = 20;
   localparam int IX_RONMAX = 21, IX_ROFFMIN = 22, IX_MASK = 23;
   localparam logic [7:0] MHT_RW_ADDR [MHT_NRW] = '{`MHT_OFS_FSK_LOW, `MHT_OFS_TONE_SEC,
      `MHT_OFS_FSK_HIGH, `MHT_OFS_ANS_DET, `MHT_OFS_OC_DELAY, `MHT_OFS_MDM_OPT,
      `MHT_OFS_TONE_FINE, `MHT_OFS_SCR_ONES, `MHT_OFS_KISSOFF, `MHT_OFS_CAR_RET,
      `MHT_OFS_ALARM2, `MHT_OFS_CAR_WAIT, `MHT_OFS_ANS_DELAY, `MHT_OFS_RING_MIN,
      `MHT_OFS_CID_GAIN, `MHT_OFS_RING_CTL, `MHT_OFS_INTR_SET, `MHT_OFS_CID_INIT,
      `MHT_OFS_GEN_STAT, `MHT_OFS_CTRL, `MHT_OFS_RING_ON_MIN, `MHT_OFS_RING_ON_MAX,
      `MHT_OFS_RING_OFF_MIN, `MHT_OFS_IRQ_MASK};
   localparam logic [7:0] MHT_RW_RST [MHT_NRW] = '{`MHT_RST_FSK_LOW, `MHT_RST_TONE_SEC,
      `MHT_RST_ZERO, `MHT_RST_ANS_DET, `MHT_RST_OC_DELAY, `MHT_RST_MDM_OPT,
      `MHT_RST_TONE_FINE, `MHT_RST_SCR_ONES, `MHT_RST_KISSOFF, `MHT_RST_CAR_RET,
      `MHT_RST_ALARM2, `MHT_RST_CAR_WAIT, `MHT_RST_ANS_DELAY, `MHT_RST_RING_MIN,
      `MHT_RST_CID_GAIN, `MHT_RST_ZERO, `MHT_RST_ZERO, `MHT_RST_ZERO, `MHT_RST_ZERO,
      `MHT_RST_ZERO, `MHT_RST_RING_ON_MIN, `MHT_RST_RING_ON_MAX, `MHT_RST_RING_OFF_MIN,
      `MHT_RST_ZERO};
endpackage

// *** inc/mht_regs.svh ***
// Function
// - High connection-delay byte counts 256 base ticks toward the FSK connection wait.
// - Low connection-delay byte adds base ticks; FSK wait is the sum of both.
// - Answer tone is accepted after persisting the programmed base-tick count.
// - After off hook, wait programmed base ticks, then sample loop overcurrent sense.
// - Fine answer tone length is used only when the seconds length is zero.
// - Nonzero seconds length sends the answer tone for that many seconds.
// - Originating 1200 bps modem needs scrambled ones for the programmed ticks.
// - Alpha and bang-one modes report 'k' when kissoff outlasts programmed 10 ms ticks.
// - Abort the call when carrier is absent after the programmed seconds.
// - In bang-seven mode the carrier wait is a handshake timeout giving 'N'.
// - In answer mode, wait programmed 53.33 ms ticks before answer tone starts.
// - A ring burst is valid only with the programmed minimum pulse count.
// - Line measurement reads loop voltage on hook and loop current off hook.
// - Ring burst on and off times must also meet the programmed ring limits.
`ifndef MHT_REGS_SVH
`define MHT_REGS_SVH
// Register offsets
`define MHT_OFS_FSK_LOW 8'h2f
`define MHT_OFS_TONE_SEC 8'h1e
`define MHT_OFS_FSK_HIGH 8'h30
`define MHT_OFS_ANS_DET 8'h31
`define MHT_OFS_OC_DELAY 8'h32
`define MHT_OFS_MDM_OPT 8'h33
`define MHT_OFS_TONE_FINE 8'h34
`define MHT_OFS_SCR_ONES 8'h35
`define MHT_OFS_KISSOFF 8'h36
`define MHT_OFS_CAR_RET 8'h37
`define MHT_OFS_ALARM2 8'h38
`define MHT_OFS_CAR_WAIT 8'h39
`define MHT_OFS_ANS_DELAY 8'h3a
`define MHT_OFS_RING_MIN 8'h3b
`define MHT_OFS_CID_GAIN 8'h3c
`define MHT_OFS_RING_CTL 8'h62
`define MHT_OFS_INTR_SET 8'h82
`define MHT_OFS_CID_INIT 8'h83
`define MHT_OFS_INTR_ST 8'hd1
`define MHT_OFS_LINE_MEAS 8'hdb
`define MHT_OFS_GEN_STAT 8'hdf
`define MHT_OFS_IRQ_STAT 8'hc0
`define MHT_OFS_IRQ_MASK 8'hc1
`define MHT_OFS_CTRL 8'hc2
`define MHT_OFS_RING_ON_MIN 8'hc3
`define MHT_OFS_RING_ON_MAX 8'hc4
`define MHT_OFS_RING_OFF_MIN 8'hc5
// Reset values of the nonzero registers, zero elsewhere
`define MHT_RST_ZERO 8'h00
`define MHT_RST_FSK_LOW 8'h3c
`define MHT_RST_TONE_SEC 8'h03
`define MHT_RST_ANS_DET 8'h3c
`define MHT_RST_OC_DELAY 8'h0c
`define MHT_RST_MDM_OPT 8'h80
`define MHT_RST_TONE_FINE 8'h5a
`define MHT_RST_SCR_ONES 8'ha2
`define MHT_RST_KISSOFF 8'h30
`define MHT_RST_CAR_RET 8'h20
`define MHT_RST_ALARM2 8'h38
`define MHT_RST_CAR_WAIT 8'h3c
`define MHT_RST_ANS_DELAY 8'h29
`define MHT_RST_RING_MIN 8'h03
`define MHT_RST_CID_GAIN 8'h04
`define MHT_RST_RING_ON_MIN 8'h02
`define MHT_RST_RING_ON_MAX 8'h1e
`define MHT_RST_RING_OFF_MIN 8'h0f
// Control register field: security mode in bits 1:0
`define MHT_CTRL_MODE_LSB 0
// Status bit positions
`define MHT_EV_ANS_TONE 0
`define MHT_EV_SCR_ONES 1
`define MHT_EV_KISSOFF 2
`define MHT_EV_CAR_BACK 3
`define MHT_EV_FSK_UP 4
`define MHT_EV_OVERCUR 5
`define MHT_EV_CAR_TMO 6
`define MHT_EV_RING 7
// Timing: base tick is 5/3 ms at a 20 ns clock
`define MHT_CLK_NS 20
`define MHT_BASE_NUM_MS 5
`define MHT_BASE_DEN 3
`define MHT_BASE_CYCLES ((`MHT_BASE_NUM_MS * 1000000) / (`MHT_BASE_DEN * `MHT_CLK_NS))
`define MHT_DIV_10MS 6
`define MHT_DIV_53MS 32
`define MHT_DIV_SEC 600
`endif

// *** inc/mht_tick_if.sv ***
`timescale 1ns/1ps
// One-cycle tick strobes shared by the timers
interface mht_tick_if;
   logic tick_base;
   logic tick_10ms;
   logic tick_53ms;
   logic tick_sec;
   modport gen (output tick_base, output tick_10ms, output tick_53ms, output tick_sec);
   modport use_ticks (input tick_base, input tick_10ms, input tick_53ms, input tick_sec);
endinterface

// *** src/mht_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser for pin levels; stage one feeds only stage two
module mht_sync #(parameter int W = 34)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_reg <= '0;
         q <= '0;
      end
      else
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// *** src/mht_tick_gen.sv ***
`timescale 1ns/1ps
module mht_tick_gen
   import mht_pkg::*;
#(parameter int unsigned BASE_CYCLES = `MHT_BASE_CYCLES)
(
   input wire logic clk,
   input wire logic arst_n,
   mht_tick_if.gen tk
);
   localparam int DIVS [3] = '{`MHT_DIV_10MS, `MHT_DIV_53MS, `MHT_DIV_SEC};
   logic [16:0] base_cnt_reg;
   logic [2:0] sub_tick;
   // Base tick every 5/3 ms; period rounds down by a third of a cycle
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         base_cnt_reg <= '0;
         tk.tick_base <= 1'b0;
      end
      else
      begin
         tk.tick_base <= (base_cnt_reg == 17'(BASE_CYCLES - 1));
         base_cnt_reg <= (base_cnt_reg == 17'(BASE_CYCLES - 1)) ? '0 : base_cnt_reg + 17'h1;
      end
   end
   // Slower ticks are exact multiples of the base tick
   for (genvar g = 0; g < 3; g++)
   begin : g_div
      logic [9:0] cnt_reg;
      logic tick_reg;
      always_ff @(posedge clk or negedge arst_n)
      begin
         if (!arst_n)
         begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
         end
         else
         begin
            tick_reg <= tk.tick_base && (cnt_reg == 10'(DIVS[g] - 1));
            if (tk.tick_base)
               cnt_reg <= (cnt_reg == 10'(DIVS[g] - 1)) ? '0 : cnt_reg + 10'h1;
         end
      end
      assign sub_tick[g] = tick_reg;
   end
   assign tk.tick_10ms = sub_tick[0];
   assign tk.tick_53ms = sub_tick[1];
   assign tk.tick_sec = sub_tick[2];
endmodule

// *** src/mht_top.sv ***
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module mht_top
   import mht_pkg::*;
#(parameter int unsigned BASE_CYCLES = `MHT_BASE_CYCLES)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic pin_off_hook,
   input wire logic pin_answer_mode,
   input wire logic pin_v22_orig,
   input wire logic pin_answer_tone_det,
   input wire logic pin_scr_ones_det,
   input wire logic pin_kissoff_det,
   input wire logic pin_carrier_det,
   input wire logic pin_ring_pulse,
   input wire logic pin_handshake_end,
   input wire logic pin_loop_over,
   input wire logic [7:0] pin_loop_volt,
   input wire logic [7:0] pin_loop_curr,
   input wire logic [7:0] pin_intrusion_state,
   output logic irq,
   output logic answer_tone_tx,
   output logic fsk_link_up,
   output logic [7:0] event_pulse,
   output logic result_n,
   output logic [7:0] kissoff_ctrl_bits
);
   mht_tick_if tk ();
   logic [33:0] sync_q;
   logic off_hook, ans_mode, v22_orig, car_det, ring_lvl, hs_lvl, loop_over;
   logic [7:0] loop_volt, loop_curr, intr_state;
   logic [3:0] prev_reg;
   logic off_rise, hs_rise, ring_rise, car_fall;
   logic [7:0] rw_reg [MHT_NRW];
   logic [7:0] status_reg, meas_reg, rdata_next;
   logic [7:0] evt_next;
   mht_mode_t mode;

   mht_tick_gen #(.BASE_CYCLES(BASE_CYCLES)) u_tick (
      .clk(clk),
      .arst_n(arst_n),
      .tk(tk.gen)
   );

   // Every pin crosses two flops before any logic sees it
   mht_sync #(.W(34)) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .d({pin_off_hook, pin_answer_mode, pin_v22_orig, pin_answer_tone_det,
         pin_scr_ones_det, pin_kissoff_det, pin_carrier_det, pin_ring_pulse,
         pin_handshake_end, pin_loop_over, pin_loop_volt, pin_loop_curr,
         pin_intrusion_state}),
      .q(sync_q)
   );
   logic ans_det, scr_det, kiss_det;
   assign {off_hook, ans_mode, v22_orig, ans_det, scr_det, kiss_det, car_det, ring_lvl,
      hs_lvl, loop_over, loop_volt, loop_curr, intr_state} = sync_q;
   assign mode = mht_mode_t'(rw_reg[IX_CTRL][`MHT_CTRL_MODE_LSB +: 2]);

   // Edge detection on the synchronised levels
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         prev_reg <= '0;
      else
         prev_reg <= {off_hook, hs_lvl, ring_lvl, car_det};
   end
   assign off_rise = off_hook && !prev_reg[3];
   assign hs_rise = hs_lvl && !prev_reg[2];
   assign ring_rise = ring_lvl && !prev_reg[1];
   assign car_fall = !car_det && prev_reg[0];

   // Plain read/write bytes; each holds its own default after reset
   for (genvar i = 0; i < MHT_NRW; i++)
   begin : g_rw
      always_ff @(posedge clk or negedge arst_n)
      begin
         if (!arst_n)
            rw_reg[i] <= MHT_RW_RST[i];
         else if (reg_wr && reg_addr == MHT_RW_ADDR[i])
            rw_reg[i] <= reg_wdata;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rdata_next = 8'h00;
      for (int i = 0; i < MHT_NRW; i++)
         if (reg_addr == MHT_RW_ADDR[i])
            rdata_next = rw_reg[i];
      case (reg_addr)
         `MHT_OFS_IRQ_STAT: rdata_next = status_reg;
         `MHT_OFS_LINE_MEAS: rdata_next = meas_reg;
         `MHT_OFS_INTR_ST: rdata_next = intr_state;
         default: ;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= reg_rd ? rdata_next : 8'h00;
   end

   // Voltage on hook, current off hook
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         meas_reg <= 8'h00;
      else
         meas_reg <= off_hook ? loop_curr : loop_volt;
   end

   // Persistence detectors: answer tone, scrambled ones, kissoff, carrier
   logic [3:0] det_in, det_tick, det_hit, det_fired;
   logic [7:0] det_cnt [4];
   logic [7:0] det_lim [4];
   localparam logic [3:0] DET_STRICT = 4'h4;  // Kissoff must outlast its limit
   assign det_in = {car_det, kiss_det, scr_det && v22_orig, ans_det};
   assign det_tick = {tk.tick_base, tk.tick_10ms, tk.tick_base, tk.tick_base};
   assign det_lim[0] = rw_reg[IX_ADET];
   assign det_lim[1] = rw_reg[IX_SCR];
   assign det_lim[2] = rw_reg[IX_KISS];
   assign det_lim[3] = rw_reg[IX_CRET];
   for (genvar g = 0; g < 4; g++)
   begin : g_det
      // Counter saturates so a long tone cannot wrap and fire twice
      assign det_hit[g] = det_in[g] && !det_fired[g] &&
         (DET_STRICT[g] ? det_cnt[g] > det_lim[g] : det_cnt[g] >= det_lim[g]);
      always_ff @(posedge clk or negedge arst_n)
      begin
         if (!arst_n)
         begin
            det_cnt[g] <= 8'h00;
            det_fired[g] <= 1'b0;
         end
         else if (!det_in[g])
         begin
            det_cnt[g] <= 8'h00;
            det_fired[g] <= 1'b0;
         end
         else
         begin
            if (det_tick[g] && det_cnt[g] != 8'hff)
               det_cnt[g] <= det_cnt[g] + 8'h01;
            if (det_hit[g])
               det_fired[g] <= 1'b1;
         end
      end
   end

   // Carrier return only counts after a loss
   logic car_lost_reg;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         car_lost_reg <= 1'b0;
      else if (car_fall)
         car_lost_reg <= 1'b1;
      else if (det_hit[3])
         car_lost_reg <= 1'b0;
   end

   // Overcurrent check: delay after going off hook, then one sample
   logic oc_busy_reg, oc_done;
   logic [7:0] oc_cnt_reg;
   assign oc_done = oc_busy_reg && off_hook && oc_cnt_reg >= rw_reg[IX_OCD];
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         oc_busy_reg <= 1'b0;
         oc_cnt_reg <= 8'h00;
      end
      else if (off_rise)
      begin
         oc_busy_reg <= 1'b1;
         oc_cnt_reg <= 8'h00;
      end
      else if (!off_hook || oc_done)
         oc_busy_reg <= 1'b0;
      else if (oc_busy_reg && tk.tick_base)
         oc_cnt_reg <= oc_cnt_reg + 8'h01;
   end

   // FSK connection wait: high byte times 256 plus low byte, in base ticks
   logic fsk_busy_reg, fsk_done;
   logic [15:0] fsk_cnt_reg, fsk_target;
   assign fsk_target = {rw_reg[IX_FSKH], 8'h00} + {8'h00, rw_reg[IX_FSKL]};
   assign fsk_done = fsk_busy_reg && fsk_cnt_reg >= fsk_target;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fsk_busy_reg <= 1'b0;
         fsk_cnt_reg <= 16'h0000;
         fsk_link_up <= 1'b0;
      end
      else if (!off_hook)
      begin
         fsk_busy_reg <= 1'b0;
         fsk_link_up <= 1'b0;
      end
      else if (hs_rise)
      begin
         fsk_busy_reg <= 1'b1;
         fsk_cnt_reg <= 16'h0000;
      end
      else if (fsk_done)
      begin
         fsk_busy_reg <= 1'b0;
         fsk_link_up <= 1'b1;
      end
      else if (fsk_busy_reg && tk.tick_base)
         fsk_cnt_reg <= fsk_cnt_reg + 16'h0001;
   end

   // Carrier wait in seconds from off hook; handshake timeout in bang-seven
   logic cw_busy_reg, cw_expire;
   logic [7:0] cw_cnt_reg;
   assign cw_expire = cw_busy_reg && !car_det && cw_cnt_reg >= rw_reg[IX_CWAIT];
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cw_busy_reg <= 1'b0;
         cw_cnt_reg <= 8'h00;
      end
      else if (off_rise)
      begin
         cw_busy_reg <= 1'b1;
         cw_cnt_reg <= 8'h00;
      end
      else if (!off_hook || car_det || cw_expire)
         cw_busy_reg <= 1'b0;
      else if (cw_busy_reg && tk.tick_sec)
         cw_cnt_reg <= cw_cnt_reg + 8'h01;
   end

   // Answer sequence: start delay, then tone of seconds or fine length
   mht_ans_t ans_state;
   logic [7:0] ans_cnt_reg;
   logic use_sec, tone_end;
   assign use_sec = rw_reg[IX_TSEC] != 8'h00;
   assign tone_end = use_sec ? ans_cnt_reg >= rw_reg[IX_TSEC] : ans_cnt_reg >= rw_reg[IX_TFINE];
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ans_state <= ANS_IDLE;
         ans_cnt_reg <= 8'h00;
         answer_tone_tx <= 1'b0;
      end
      else if (!off_hook)
      begin
         ans_state <= ANS_IDLE;
         answer_tone_tx <= 1'b0;
      end
      else
      begin
         case (ans_state)
            ANS_IDLE:
               if (off_rise && ans_mode)
               begin
                  ans_state <= ANS_DELAY;
                  ans_cnt_reg <= 8'h00;
               end
            ANS_DELAY:
               if (ans_cnt_reg >= rw_reg[IX_ADLY])
               begin
                  ans_state <= ANS_TONE;
                  ans_cnt_reg <= 8'h00;
                  answer_tone_tx <= 1'b1;
               end
               else if (tk.tick_53ms)
                  ans_cnt_reg <= ans_cnt_reg + 8'h01;
            ANS_TONE:
               if (tone_end)
               begin
                  ans_state <= ANS_DONE;
                  answer_tone_tx <= 1'b0;
               end
               else if (use_sec ? tk.tick_sec : tk.tick_base)
                  ans_cnt_reg <= ans_cnt_reg + 8'h01;
            ANS_DONE: ans_state <= ANS_DONE;
            default: ans_state <= ANS_IDLE;
         endcase
      end
   end

   // Ring burst: pulse count, on length and closing gap in 53.33 ms ticks
   logic ring_act_reg, ring_end, ring_valid;
   logic [7:0] ring_np_reg, ring_el_reg, ring_gap_reg, ring_on_reg;
   assign ring_end = ring_act_reg && !ring_rise && ring_gap_reg >= rw_reg[IX_ROFFMIN];
   assign ring_valid = ring_end && ring_np_reg >= rw_reg[IX_RPMIN] &&
      ring_on_reg >= rw_reg[IX_RONMIN] && ring_on_reg <= rw_reg[IX_RONMAX];
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ring_act_reg <= 1'b0;
         ring_np_reg <= 8'h00;
         ring_el_reg <= 8'h00;
         ring_gap_reg <= 8'h00;
         ring_on_reg <= 8'h00;
      end
      else if (ring_rise)
      begin
         ring_act_reg <= 1'b1;
         ring_gap_reg <= 8'h00;
         ring_np_reg <= !ring_act_reg ? 8'h01 :
            (ring_np_reg == 8'hff ? ring_np_reg : ring_np_reg + 8'h01);
         ring_el_reg <= ring_act_reg ? ring_el_reg : 8'h00;
         ring_on_reg <= ring_act_reg ? ring_el_reg : 8'h00;
      end
      else if (ring_end)
         ring_act_reg <= 1'b0;
      else if (ring_act_reg && tk.tick_53ms)
      begin
         // Saturate so a long burst is rejected, not wrapped into range
         if (ring_el_reg != 8'hff)
            ring_el_reg <= ring_el_reg + 8'h01;
         if (ring_gap_reg != 8'hff)
            ring_gap_reg <= ring_gap_reg + 8'h01;
      end
   end

   // Event gathering; kissoff 'k' only in alpha and bang-one modes
   always_comb
   begin
      evt_next = 8'h00;
      evt_next[`MHT_EV_ANS_TONE] = det_hit[0];
      evt_next[`MHT_EV_SCR_ONES] = det_hit[1];
      evt_next[`MHT_EV_KISSOFF] = det_hit[2] && (mode == MODE_ALPHA || mode == MODE_BANG1);
      evt_next[`MHT_EV_CAR_BACK] = det_hit[3] && car_lost_reg;
      evt_next[`MHT_EV_FSK_UP] = fsk_done && !hs_rise;
      evt_next[`MHT_EV_OVERCUR] = oc_done && loop_over;
      evt_next[`MHT_EV_CAR_TMO] = cw_expire && off_hook && !off_rise;
      evt_next[`MHT_EV_RING] = ring_valid;
   end

   // Status bits are sticky, write one to clear; a new event beats the clear
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         status_reg <= 8'h00;
      else if (reg_wr && reg_addr == `MHT_OFS_IRQ_STAT)
         status_reg <= (status_reg & ~reg_wdata) | evt_next;
      else
         status_reg <= status_reg | evt_next;
   end

   // Registered event outputs and bang-seven result code
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         event_pulse <= 8'h00;
         result_n <= 1'b0;
         irq <= 1'b0;
         kissoff_ctrl_bits <= 8'h00;
      end
      else
      begin
         event_pulse <= evt_next;
         result_n <= evt_next[`MHT_EV_CAR_TMO] && mode == MODE_BANG7;
         irq <= |(status_reg & rw_reg[IX_MASK]);
         kissoff_ctrl_bits <= (mode == MODE_BANG7) ? rw_reg[IX_KISS] : 8'h00;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_oc_sample;
      oc_done && loop_over;
   endsequence
   sequence s_cw_timeout;
      cw_expire && off_hook && !off_rise;
   endsequence

   AST_MEAS_READ: assert property (
      reg_rd && reg_addr == `MHT_OFS_LINE_MEAS |=> reg_rdata == $past(meas_reg))
      else $error("line measurement read wrong");
   AST_OC_FLAG: assert property (
      s_oc_sample |=> event_pulse[`MHT_EV_OVERCUR] && $past(oc_cnt_reg) >= $past(rw_reg[IX_OCD]))
      else $error("overcurrent not reported after delay");
   AST_FSK_WAIT: assert property (
      $rose(fsk_link_up) |-> $past(fsk_cnt_reg) >= $past(fsk_target))
      else $error("fsk link up before wait ended");
   AST_FSK_SUM: assert property (
      fsk_busy_reg && off_hook && !hs_rise && fsk_cnt_reg == fsk_target |=> fsk_link_up)
      else $error("fsk link not up at summed delay");
   AST_ANS_FINE: assert property (
      ans_state == ANS_TONE && !use_sec && ans_cnt_reg >= rw_reg[IX_TFINE] && off_hook
      |=> !answer_tone_tx ##1 !answer_tone_tx)
      else $error("fine answer tone overran");
   AST_ANS_START: assert property (
      $rose(answer_tone_tx) |-> $past(ans_cnt_reg) >= $past(rw_reg[IX_ADLY]))
      else $error("answer tone started early");
   AST_CAR_ABORT: assert property (
      s_cw_timeout |=> event_pulse[`MHT_EV_CAR_TMO] && !cw_busy_reg)
      else $error("carrier timeout not reported");
   AST_KISS_B7: assert property (
      mode == MODE_BANG7 && $past(mode) == MODE_BANG7 |-> !event_pulse[`MHT_EV_KISSOFF])
      else $error("kissoff reported in bang-seven mode");
   AST_RING_MIN: assert property (
      event_pulse[`MHT_EV_RING] |-> $past(ring_np_reg) >= $past(rw_reg[IX_RPMIN]))
      else $error("ring accepted with too few pulses");
endmodule
